// >>> logic/torque_calibration_scaling.sv
`timescale 1ns/1ps
module torque_calibration_scaling #(
  parameter int unsigned MAX_DET_CYC = torque_cal_pkg::MAX_DET_CYC,
  parameter int          VAL_W       = 24
) (
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  input  wire logic signed [15:0] sample_mv,
  input  wire logic               sample_valid,
  input  wire logic               rot_pulse,
  output logic signed [VAL_W-1:0] load_value,
  output logic [31:0]             speed_value,
  output logic [7:0]              speed_div,
  output logic                    low_speed_mode,
  output logic                    alarm,
  output logic                    calibration_error_indication,
  output logic                    cal_done_msg,
  output logic                    item_select_return
);
  localparam int NUM_W = 40;
  localparam int DEN_W = 48;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic signed [31:0] v, input int lim);
    in_range = (v != 0) && (v <= lim) && (v >= -lim);
  endfunction : in_range

  // ----------------------------------------------------------------
  // apb slave: setup cycle latches the answer, one access cycle
  // ----------------------------------------------------------------
  torque_cal_pkg::ctrl_s   ctrl_reg;
  logic signed [15:0]      rated_reg, zero_reg, cur_mv_reg, rated_in_reg;
  logic signed [VAL_W-1:0] cap_reg, actual_reg, offset_reg, cap_in_reg;
  logic signed [VAL_W-1:0] raw_load_reg, dz_amount_reg;
  logic [VAL_W-1:0]        dzlim_reg;
  logic [13:0]             enc_reg;
  logic                    v_in_reg, c_in_reg;
  logic                    dz_err_reg, alarm_reg, calibration_error_indication_reg, done_reg, ret_reg;
  logic                    busy_reg;
  logic                    wr_en, wr_ok;
  logic [31:0]             rd_next;
  logic                    err_next;

  assign wr_en = psel && penable && pready && pwrite;
  assign wr_ok = wr_en && !ctrl_reg.protect;

  // read mux, unmapped offsets flag an error and read zero
  always_comb begin
    rd_next  = 32'h0;
    err_next = 1'b0;
    if (paddr == torque_cal_pkg::OFS_CTRL) begin
      rd_next = 32'(ctrl_reg);
    end else if (paddr == torque_cal_pkg::OFS_RATED) begin
      rd_next = 32'(rated_reg);
    end else if (paddr == torque_cal_pkg::OFS_CAP) begin
      rd_next = 32'(cap_reg);
    end else if (paddr == torque_cal_pkg::OFS_ACTUAL) begin
      rd_next = 32'(actual_reg);
    end else if (paddr == torque_cal_pkg::OFS_ZERO) begin
      rd_next = 32'(zero_reg);
    end else if (paddr == torque_cal_pkg::OFS_OFFSET) begin
      rd_next = 32'(offset_reg);
    end else if (paddr == torque_cal_pkg::OFS_DZLIM) begin
      rd_next = 32'(dzlim_reg);
    end else if (paddr == torque_cal_pkg::OFS_ENC) begin
      rd_next = 32'(enc_reg);
    end else if (paddr == torque_cal_pkg::OFS_CMD) begin
      rd_next = 32'h0;
    end else if (paddr == torque_cal_pkg::OFS_STATUS) begin
      rd_next = {25'h0, c_in_reg, v_in_reg, low_speed_mode, dz_err_reg, done_reg, calibration_error_indication_reg, alarm_reg};
    end else if (paddr == torque_cal_pkg::OFS_LOAD) begin
      rd_next = 32'(load_value);
    end else if (paddr == torque_cal_pkg::OFS_SPEED) begin
      rd_next = speed_value;
    end else if (paddr == torque_cal_pkg::OFS_DZAMT) begin
      rd_next = 32'(dz_amount_reg);
    end else begin
      err_next = 1'b1;
    end
  end

  // answer registered in the setup cycle so outputs come from flops
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_next : 32'h0;
      pslverr <= psel && !penable && err_next;
    end
  end

  // ----------------------------------------------------------------
  // plain settings
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg   <= torque_cal_pkg::CTRL_RST;
      zero_reg   <= 16'sh0;
      offset_reg <= '0;
      dzlim_reg  <= VAL_W'(torque_cal_pkg::DZLIM_RST);
      enc_reg    <= 14'(torque_cal_pkg::ENC_RST);
    end else if (wr_en) begin
      // protect itself stays writable so it can be released
      if (paddr == torque_cal_pkg::OFS_CTRL) begin
        ctrl_reg.protect <= pwdata[1];
        if (!ctrl_reg.protect) begin
          ctrl_reg.volt_5v    <= pwdata[0];
          ctrl_reg.pulse_rate <= torque_cal_pkg::pulse_rate_e'(pwdata[4:2]);
          ctrl_reg.speed_div  <= pwdata[6:5];
        end
      end else if (wr_ok && paddr == torque_cal_pkg::OFS_ZERO) begin
        zero_reg <= pwdata[15:0];
      end else if (wr_ok && paddr == torque_cal_pkg::OFS_OFFSET) begin
        offset_reg <= pwdata[VAL_W-1:0];
      end else if (wr_ok && paddr == torque_cal_pkg::OFS_DZLIM) begin
        dzlim_reg <= (pwdata > 32'(torque_cal_pkg::VAL_MAX)) ? dzlim_reg : pwdata[VAL_W-1:0];
      end else if (wr_ok && paddr == torque_cal_pkg::OFS_ENC) begin
        enc_reg <= pwdata[13:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration: equivalent input and actual load
  // ----------------------------------------------------------------
  logic [31:0] v_lim;
  logic        eq_go, act_go, eq_ok, act_ok;
  logic signed [31:0] act_in;

  assign v_lim  = ctrl_reg.volt_5v ? 32'(torque_cal_pkg::V5_MAX_MV) : 32'(torque_cal_pkg::V10_MAX_MV);
  assign eq_go  = v_in_reg && c_in_reg;
  assign eq_ok  = in_range(32'(rated_in_reg), int'(v_lim))
               && in_range(32'(cap_in_reg), torque_cal_pkg::VAL_MAX)
               && (rated_in_reg != zero_reg);
  assign act_in = 32'(signed'(pwdata));
  assign act_go = wr_ok && paddr == torque_cal_pkg::OFS_ACTUAL;
  assign act_ok = in_range(act_in, torque_cal_pkg::VAL_MAX)
               && in_range(32'(cur_mv_reg), int'(v_lim)) && (cur_mv_reg != zero_reg);

  // entries wait until both halves are present
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      v_in_reg     <= 1'b0;
      c_in_reg     <= 1'b0;
      rated_in_reg <= 16'sh0;
      cap_in_reg   <= '0;
    end else if (eq_go) begin
      v_in_reg <= 1'b0;
      c_in_reg <= 1'b0;
    end else if (wr_ok && paddr == torque_cal_pkg::OFS_RATED) begin
      rated_in_reg <= pwdata[15:0];
      v_in_reg     <= 1'b1;
    end else if (wr_ok && paddr == torque_cal_pkg::OFS_CAP) begin
      cap_in_reg <= pwdata[VAL_W-1:0];
      c_in_reg   <= 1'b1;
    end
  end

  // settings change only on success
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rated_reg  <= 16'(torque_cal_pkg::RATED_RST);
      cap_reg    <= VAL_W'(torque_cal_pkg::CAP_RST);
      actual_reg <= VAL_W'(torque_cal_pkg::CAP_RST);
    end else if (eq_go && eq_ok) begin
      rated_reg  <= rated_in_reg;
      cap_reg    <= cap_in_reg;
      actual_reg <= cap_in_reg;
    end else if (act_go && act_ok) begin
      rated_reg  <= cur_mv_reg;
      cap_reg    <= pwdata[VAL_W-1:0];
      actual_reg <= pwdata[VAL_W-1:0];
    end
  end

  // sticky outcome flags plus the one-cycle return pulse, a new event wins over a clear
  logic clr_st, dz_go, dz_fail;
  assign clr_st = wr_en && paddr == torque_cal_pkg::OFS_STATUS;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      alarm_reg <= 1'b0;
      calibration_error_indication_reg  <= 1'b0;
      done_reg  <= 1'b0;
      ret_reg   <= 1'b0;
    end else begin
      ret_reg <= (eq_go && eq_ok) || (act_go && act_ok);
      if ((eq_go && !eq_ok) || (act_go && !act_ok) || dz_fail) begin
        alarm_reg <= 1'b1;
      end else if (clr_st && pwdata[torque_cal_pkg::ST_ALARM]) begin
        alarm_reg <= 1'b0;
      end
      if (act_go && !act_ok) begin
        calibration_error_indication_reg <= 1'b1;
      end else if ((clr_st && pwdata[torque_cal_pkg::ST_CALIBRATION_ERROR_INDICATION]) || (act_go && act_ok)) begin
        calibration_error_indication_reg <= 1'b0;
      end
      if ((eq_go && eq_ok) || (act_go && act_ok)) begin
        done_reg <= 1'b1;
      end else if (clr_st && pwdata[torque_cal_pkg::ST_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // digital zero: accumulated amount from the zero-calibration point
  // ----------------------------------------------------------------
  logic [VAL_W-1:0]  raw_abs;
  assign dz_go   = wr_en && paddr == torque_cal_pkg::OFS_CMD && pwdata[0];
  assign raw_abs = raw_load_reg[VAL_W-1] ? VAL_W'(-raw_load_reg) : VAL_W'(raw_load_reg);
  assign dz_fail = dz_go && (raw_abs > dzlim_reg);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dz_amount_reg <= '0;
      dz_err_reg    <= 1'b0;
    end else begin
      if (dz_go && !dz_fail) begin
        dz_amount_reg <= raw_load_reg;
      end else if (wr_ok && paddr == torque_cal_pkg::OFS_ZERO) begin
        dz_amount_reg <= '0;
      end
      if (dz_fail) begin
        dz_err_reg <= 1'b1;
      end else if (clr_st && pwdata[torque_cal_pkg::ST_DZERR]) begin
        dz_err_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // rotation pulses: two-flop sync, period timing
  // ----------------------------------------------------------------
  logic [2:0]  pls_sync_reg;
  logic [31:0] gap_reg, period_reg;
  logic [13:0] ppr, pcnt_reg;
  logic        hs, low_next, edge_seen, meas_reg;

  assign edge_seen = pls_sync_reg[1] && !pls_sync_reg[2];
  assign hs        = ctrl_reg.pulse_rate inside {torque_cal_pkg::PR_60HS, torque_cal_pkg::PR_90HS};
  assign low_next  = ctrl_reg.pulse_rate == torque_cal_pkg::PR_ENC
                  && enc_reg > 14'(torque_cal_pkg::LOW_ENC_MIN);

  // pulses per revolution
  always_comb begin
    case (ctrl_reg.pulse_rate)
      torque_cal_pkg::PR_4:    ppr = 14'd4;
      torque_cal_pkg::PR_60,
      torque_cal_pkg::PR_60HS: ppr = 14'd60;
      torque_cal_pkg::PR_90,
      torque_cal_pkg::PR_90HS: ppr = 14'd90;
      torque_cal_pkg::PR_ENC:  ppr = (enc_reg == 14'd0) ? 14'd1 : enc_reg;
      default:                 ppr = 14'd1;
    endcase
  end

  // fast variants time a whole revolution, plain ones a single pulse
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pls_sync_reg <= 3'h0;
      gap_reg      <= 32'h0;
      pcnt_reg     <= 14'h0;
      period_reg   <= 32'h0;
      meas_reg     <= 1'b0;
    end else begin
      pls_sync_reg <= {pls_sync_reg[1:0], rot_pulse};
      meas_reg     <= 1'b0;
      if (gap_reg >= MAX_DET_CYC) begin
        gap_reg    <= 32'h0;  // stopped: report zero
        pcnt_reg   <= 14'h0;
        period_reg <= 32'h0;
        meas_reg   <= 1'b1;
      end else if (edge_seen && (!hs || pcnt_reg >= ppr - 14'd1)) begin
        period_reg <= gap_reg + 32'h1;
        gap_reg    <= 32'h0;
        pcnt_reg   <= 14'h0;
        meas_reg   <= 1'b1;
      end else begin
        gap_reg  <= gap_reg + 32'h1;
        pcnt_reg <= edge_seen ? pcnt_reg + 14'h1 : pcnt_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared restoring divider: load scaling and speed
  // ----------------------------------------------------------------
  torque_cal_pkg::div_state_e div_state_reg;
  logic [NUM_W-1:0]  num_reg;
  logic [DEN_W-1:0]  den_reg;
  logic [DEN_W:0]    rem_reg, rem_sh;
  logic [5:0]        step_reg;
  logic              job_spd_reg, neg_reg, spd_pend, ld_pend;
  logic signed [16:0] dv, dspan;
  logic [16:0]       dv_abs, span_abs, cap_abs;
  logic [NUM_W-1:0]  spd_num;

  assign dv       = 17'(cur_mv_reg) - 17'(zero_reg);
  assign dspan    = 17'(rated_reg) - 17'(zero_reg);
  assign dv_abs   = dv[16] ? 17'(-dv) : 17'(dv);
  assign span_abs = dspan[16] ? 17'(-dspan) : 17'(dspan);
  assign cap_abs  = cap_reg[VAL_W-1] ? 17'(-cap_reg) : 17'(cap_reg);
  assign spd_num  = NUM_W'(64'(torque_cal_pkg::CLK_HZ) * (low_next ? 64'd600 : 64'd60));
  assign rem_sh   = {rem_reg[DEN_W-1:0], num_reg[NUM_W-1]};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_state_reg <= torque_cal_pkg::DIV_IDLE;
      num_reg <= '0;
      den_reg <= '0;
      rem_reg <= '0;
      step_reg <= 6'h0;
      job_spd_reg <= 1'b0;
      neg_reg <= 1'b0;
      spd_pend <= 1'b0;
      ld_pend <= 1'b0;
      raw_load_reg <= '0;
      speed_value <= 32'h0;
      cur_mv_reg <= 16'sh0;
      busy_reg <= 1'b0;
    end else begin
      if (sample_valid) begin
        cur_mv_reg <= sample_mv;
        ld_pend    <= 1'b1;
      end
      if (meas_reg) begin
        spd_pend <= 1'b1;
      end
      case (div_state_reg)
        torque_cal_pkg::DIV_IDLE: begin
          rem_reg  <= '0;
          step_reg <= 6'h0;
          if (spd_pend && !meas_reg) begin
            spd_pend <= 1'b0;
            if (period_reg == 32'h0) begin
              speed_value <= 32'h0;
            end else begin
              job_spd_reg   <= 1'b1;
              busy_reg      <= 1'b1;
              num_reg       <= spd_num;
              den_reg       <= hs ? DEN_W'(period_reg) : DEN_W'(period_reg) * DEN_W'(ppr);
              div_state_reg <= torque_cal_pkg::DIV_RUN;
            end
          end else if (ld_pend && !sample_valid) begin
            ld_pend       <= 1'b0;
            job_spd_reg   <= 1'b0;
            busy_reg      <= 1'b1;
            neg_reg       <= dv[16] ^ dspan[16] ^ cap_reg[VAL_W-1];
            num_reg       <= NUM_W'(34'(dv_abs) * 34'(cap_abs));
            den_reg       <= (span_abs == 17'h0) ? DEN_W'(1) : DEN_W'(span_abs);
            div_state_reg <= torque_cal_pkg::DIV_RUN;
          end
        end
        torque_cal_pkg::DIV_RUN: begin
          if (rem_sh >= {1'b0, den_reg}) begin
            rem_reg <= rem_sh - {1'b0, den_reg};
            num_reg <= {num_reg[NUM_W-2:0], 1'b1};
          end else begin
            rem_reg <= rem_sh;
            num_reg <= {num_reg[NUM_W-2:0], 1'b0};
          end
          step_reg <= step_reg + 6'h1;
          if (step_reg == 6'(NUM_W - 1)) begin
            div_state_reg <= torque_cal_pkg::DIV_DONE;
          end
        end
        torque_cal_pkg::DIV_DONE: begin
          busy_reg <= 1'b0;
          if (job_spd_reg) begin
            speed_value <= num_reg[31:0];
          end else begin
            raw_load_reg <= neg_reg ? -VAL_W'(num_reg) : VAL_W'(num_reg);
          end
          div_state_reg <= torque_cal_pkg::DIV_IDLE;
        end
        default: div_state_reg <= torque_cal_pkg::DIV_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      load_value     <= '0;
      speed_div      <= 8'h0;
      low_speed_mode <= 1'b0;
      alarm          <= 1'b0;
      calibration_error_indication <= 1'b0;
      cal_done_msg   <= 1'b0;
      item_select_return <= 1'b0;
    end else begin
      load_value     <= raw_load_reg - dz_amount_reg - offset_reg;
      low_speed_mode <= low_next;
      // division in tenths of rpm
      case (ctrl_reg.speed_div)
        2'h0:    speed_div <= low_next ? 8'd1 : 8'd10;
        2'h1:    speed_div <= low_next ? 8'd2 : 8'd20;
        2'h2:    speed_div <= low_next ? 8'd5 : 8'd50;
        default: speed_div <= low_next ? 8'd10 : 8'd100;
      endcase
      alarm          <= alarm_reg || dz_err_reg;
      calibration_error_indication <= calibration_error_indication_reg;
      cal_done_msg   <= done_reg;
      item_select_return <= ret_reg;
    end
  end
endmodule : torque_calibration_scaling

// >>> logic/torque_cal_pkg.sv
// ----------------------------------------------------------------------------
// Notes on behaviour
// - equivalent calibration runs only once both rated voltage and capacity are entered
// - 10 V range: rated -10.000..10.000 V nonzero, capacity -99999..99999 nonzero
// - 5 V range: rated -5.000..5.000 V nonzero, same capacity range
// - equivalent success copies capacity into actual-load setting; error keeps it
// - equivalent failure sounds alarm, no return to item selection
// - actual load nonzero +-99999; success stores present voltage as rated output
// - actual failure: alarm plus error indication; success: done message, item return
// - displayed load is computed load minus signed offset; zero disables it
// - digital zero refused with error when absolute load exceeds limit
// - limit is checked against accumulated zeroing from the zero-calibration point
// - protect bit 1 blocks all calibration setting writes but not the digital zero command, 0 allows them
// - pulse-rate codes 0..6 decode to 1,4,60,90,encoder,60 fast,90 fast
// - encoder option uses encoder pulses-per-revolution count
// - 60/90 plain settings measure single pulse periods, coarse at high speed
// - fast variants time whole revolutions, slower response, higher minimum speed
// - low speed mode when encoder option selected and count over 600
// - voltage-input code 0 selects 10 V range, 1 selects 5 V
// ----------------------------------------------------------------------------
package torque_cal_pkg;
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned MAX_DET_MS = 1000;
  localparam int unsigned MAX_DET_CYC = CLK_HZ / 1000 * MAX_DET_MS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RATED  = 8'h04;
  localparam logic [7:0] OFS_CAP    = 8'h08;
  localparam logic [7:0] OFS_ACTUAL = 8'h0c;
  localparam logic [7:0] OFS_ZERO   = 8'h10;
  localparam logic [7:0] OFS_OFFSET = 8'h14;
  localparam logic [7:0] OFS_DZLIM  = 8'h18;
  localparam logic [7:0] OFS_ENC    = 8'h1c;
  localparam logic [7:0] OFS_CMD    = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_LOAD   = 8'h28;
  localparam logic [7:0] OFS_SPEED  = 8'h2c;
  localparam logic [7:0] OFS_DZAMT  = 8'h30;

  // status bit positions
  localparam int ST_ALARM = 0;
  localparam int ST_CALIBRATION_ERROR_INDICATION  = 1;
  localparam int ST_DONE  = 2;
  localparam int ST_DZERR = 3;
  localparam int ST_LOW   = 4;

  // limits and reset values
  localparam int V10_MAX_MV   = 10000;
  localparam int V5_MAX_MV    = 5000;
  localparam int VAL_MAX      = 99999;
  localparam int LOW_ENC_MIN  = 600;
  localparam int RATED_RST    = 10000;
  localparam int CAP_RST      = 10000;
  localparam int DZLIM_RST    = 99999;
  localparam int ENC_RST      = 3600;

  typedef enum logic [2:0] {
    PR_1 = 3'h0, PR_4 = 3'h1, PR_60 = 3'h2, PR_90 = 3'h3,
    PR_ENC = 3'h4, PR_60HS = 3'h5, PR_90HS = 3'h6, PR_RSV = 3'h7
  } pulse_rate_e;

  typedef enum logic [1:0] {DIV_IDLE = 2'h0, DIV_RUN = 2'h1, DIV_DONE = 2'h2} div_state_e;

  typedef struct packed {
    logic [1:0]  speed_div;
    pulse_rate_e pulse_rate;
    logic        protect;
    logic        volt_5v;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{speed_div: 2'h0, pulse_rate: PR_4, protect: 1'b0, volt_5v: 1'b0};
endpackage : torque_cal_pkg

// >>> verification/sensor_model.sv
`timescale 1ns/1ps
module sensor_model (
  input  wire logic               core_clk,
  input  wire logic signed [15:0] level_mv,
  input  wire logic               spin,
  output logic signed [15:0]      sample_mv,
  output logic                    sample_valid,
  output logic                    rot_pulse
);
  logic [9:0] tick_reg = 10'h000;
  // ------------------------------
  // sensor and pulse pacing
  // ------------------------------
  // free counter paces samples every 64 cycles and pulses every 1024
  always @(posedge core_clk) tick_reg <= tick_reg + 10'h001;
  // data scrambled off the strobe so nobody can rely on a stale value
  assign sample_valid = (tick_reg[5:0] == 6'h00);
  assign sample_mv    = sample_valid ? level_mv : ~level_mv;
  assign rot_pulse    = spin && (tick_reg[9:8] == 2'h0); // pin idles low when stopped
endmodule : sensor_model

// >>> verification/torque_cal_chk.sv
`timescale 1ns/1ps
module torque_cal_chk #(
  parameter int unsigned MAX_DET_CYC = 2000,
  parameter int          VAL_W       = 24
) (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [7:0]  speed_div,
  input wire logic        low_speed_mode,
  input wire logic        alarm,
  input wire logic        calibration_error_indication,
  input wire logic        cal_done_msg,
  input wire logic        item_select_return
);
  // ------------------------------
  // bus timing and event outputs
  // ------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_pready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_return_pulse: assert property (item_select_return |=> !item_select_return)
    else $error("return longer than one cycle");
  a_return_done: assert property ($rose(item_select_return) |-> ##[0:1] cal_done_msg)
    else $error("return without done message");
  a_calibration_error_indication_alarm: assert property ($rose(calibration_error_indication) |-> ##[0:1] alarm)
    else $error("error shown without alarm");
  a_div_low: assert property (low_speed_mode |-> speed_div inside {8'h01, 8'h02, 8'h05, 8'h0a})
    else $error("bad low speed division");
endmodule : torque_cal_chk

bind torque_calibration_scaling torque_cal_chk #(.MAX_DET_CYC(MAX_DET_CYC), .VAL_W(VAL_W)) u_chk (
  .core_clk, .arst_n, .psel, .penable, .pready, .prdata, .pslverr, .speed_div, .low_speed_mode,
  .alarm, .calibration_error_indication, .cal_done_msg, .item_select_return
);

// >>> verification/test_torque_calibration_scaling.sv
`timescale 1ns/1ps
module test_torque_calibration_scaling;
  logic               core_clk, arst_n, psel, penable, pwrite, pready, pslverr, e, spin;
  logic               sample_valid, rot_pulse, low_speed_mode, alarm, cal_done_msg, item_select_return;
  logic               calibration_error_indication;
  logic [7:0]         paddr, speed_div;
  logic [31:0]        pwdata, prdata, speed_value, q;
  logic signed [15:0] sample_mv, level_mv;
  logic signed [23:0] load_value;
  int                 errors, checks, exp_act;
  int                 tr[5] = '{5000, 10001, 3000, 5001, -5000};
  int                 tc[5] = '{5000, 777, 0, 777, -5000};
  int                 tv[5] = '{0, 0, 0, 1, 1};
  int                 dv[4] = '{10, 20, 50, 100};

  torque_calibration_scaling #(.MAX_DET_CYC(2000)) dut (
    .core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .sample_mv, .sample_valid, .rot_pulse, .load_value, .speed_value, .speed_div,
    .low_speed_mode, .alarm, .calibration_error_indication, .cal_done_msg, .item_select_return
  );
  sensor_model sensor (.core_clk, .level_mv, .spin, .sample_mv, .sample_valid, .rot_pulse);

  // ------------------------------
  // clock and bus tasks
  // ------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; a bounded wait so a dead slave cannot hang the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      wrap_up();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, spin, paddr, pwdata, level_mv} = '0;
    errors = 0;
    checks = 0;
    exp_act = 0;
    cyc(8);
    arst_n <= 1'b1;
    rd(torque_cal_pkg::OFS_CTRL, 32'(torque_cal_pkg::CTRL_RST));
    rd(torque_cal_pkg::OFS_RATED, 32'(torque_cal_pkg::RATED_RST));
    rd(torque_cal_pkg::OFS_DZLIM, 32'(torque_cal_pkg::DZLIM_RST));
    rd(torque_cal_pkg::OFS_ENC, 32'(torque_cal_pkg::ENC_RST));
    xfer(1'b0, 8'hfc, 32'h0);
    chk(32'(e), 32'h1);
    // accept and refuse cases of both input ranges; last one leaves unity gain
    for (int i = 0; i < 5; i++) begin
      wr(torque_cal_pkg::OFS_STATUS, 32'h0000000f);
      wr(torque_cal_pkg::OFS_CTRL, 32'(tv[i]));
      wr(torque_cal_pkg::OFS_RATED, 32'(tr[i]));
      cyc(4);
      chk(32'(cal_done_msg), 32'h0);
      wr(torque_cal_pkg::OFS_CAP, 32'(tc[i]));
      cyc(4);
      chk(32'(cal_done_msg), 32'(i % 4 == 0));
      chk(32'(alarm), 32'(i % 4 != 0));
      if (i % 4 == 0) exp_act = tc[i];
      rd(torque_cal_pkg::OFS_ACTUAL, 32'(exp_act));
    end
    wr(torque_cal_pkg::OFS_STATUS, 32'h0000000f);
    level_mv <= 16'sd2500;
    cyc(100);
    wr(torque_cal_pkg::OFS_ACTUAL, 32'h0);
    cyc(4);
    chk(32'(calibration_error_indication), 32'h1);
    rd(torque_cal_pkg::OFS_RATED, 32'(-5000));
    wr(torque_cal_pkg::OFS_ACTUAL, 32'd2500);
    cyc(4);
    chk(32'({calibration_error_indication, cal_done_msg}), 32'h1);
    rd(torque_cal_pkg::OFS_RATED, 32'd2500);
    wr(torque_cal_pkg::OFS_OFFSET, 32'd100);
    level_mv <= 16'sd1000;
    cyc(200);
    chk(32'(load_value), 32'd900);
    wr(torque_cal_pkg::OFS_STATUS, 32'h0000000f);
    wr(torque_cal_pkg::OFS_DZLIM, 32'd500);
    wr(torque_cal_pkg::OFS_CMD, 32'h1);
    cyc(150);
    chk(32'({alarm, load_value}), 32'h10003_84);
    wr(torque_cal_pkg::OFS_DZLIM, 32'd1000);
    wr(torque_cal_pkg::OFS_CMD, 32'h1);
    cyc(150);
    chk(32'(load_value), 32'(-100));
    // small step but large total since zero calibration must be refused
    level_mv <= 16'sd1200;
    cyc(150);
    wr(torque_cal_pkg::OFS_DZLIM, 32'd1100);
    wr(torque_cal_pkg::OFS_STATUS, 32'h0000000f);
    wr(torque_cal_pkg::OFS_CMD, 32'h1);
    cyc(150);
    chk(32'({alarm, load_value}), 32'h10000_64);
    wr(torque_cal_pkg::OFS_CTRL, 32'h3);
    wr(torque_cal_pkg::OFS_OFFSET, 32'h0);
    wr(torque_cal_pkg::OFS_CTRL, 32'h2);
    rd(torque_cal_pkg::OFS_OFFSET, 32'd100);
    rd(torque_cal_pkg::OFS_CTRL, 32'h3);
    wr(torque_cal_pkg::OFS_CTRL, 32'h0);
    rd(torque_cal_pkg::OFS_CTRL, 32'h1);
    wr(torque_cal_pkg::OFS_ENC, 32'd601);
    for (int r = 0; r < 7; r++) begin
      for (int d = 0; d < 4; d++) begin
        wr(torque_cal_pkg::OFS_CTRL, 32'((d << 5) | (r << 2)));
        cyc(3);
        chk(32'(low_speed_mode), 32'(r == 4));
        chk(32'(speed_div), 32'(dv[d] / ((r == 4) ? 10 : 1)));
      end
    end
    wr(torque_cal_pkg::OFS_CTRL, 32'h10);
    wr(torque_cal_pkg::OFS_ENC, 32'd600);
    cyc(3);
    chk(32'(low_speed_mode), 32'h0);
    spin <= 1'b1;
    cyc(3000);
    chk(speed_value, 32'd4882);
    spin <= 1'b0;
    cyc(5000);
    chk(speed_value, 32'h0);
    wrap_up();
  end
endmodule : test_torque_calibration_scaling
